// [bench/fsag_flash_model.sv]
// flash array stand-in answering reads from the guard
`timescale 1ns/1ps
module fsag_flash_model (
    input wire logic sys_clk,
    input wire fsag_pkg::fsag_cmd_t flash_cmd,
    input wire logic [16:0] flash_addr,
    output logic [7:0] flash_rdata
);
    logic [7:0] noise_ff = 8'h00;
    // outside a read the data lines wander, so a stale sample never matches
    always @(posedge sys_clk) begin
        noise_ff <= noise_ff + 8'h35;
    end
    assign flash_rdata = (flash_cmd == fsag_pkg::CMD_READ) ?
        (flash_addr[7:0] ^ 8'h3C) : noise_ff;
endmodule // fsag_flash_model

// [bench/test_flash_security_access_guard.sv]
// self-checking bench for the flash security access guard
`timescale 1ns/1ps
module test_flash_security_access_guard;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic core_req = 1'b0, core_ready, core_ack, core_denied;
    logic [1:0] core_op = 2'h0, dbg_op = 2'h0, flash_read_time;
    logic [16:0] core_addr = 17'h0, core_pc = 17'h0, dbg_addr = 17'h0;
    logic [7:0] core_wdata = 8'hC3, dbg_wdata = 8'hC3, core_rdata;
    logic dbg_req = 1'b0, dbg_scratch = 1'b0, dbg_ack, dbg_denied;
    logic [7:0] dbg_rdata, lock_rd_byte = 8'hFF, lock_we_byte = 8'hFF;
    fsag_pkg::fsag_cmd_t flash_cmd;
    logic [16:0] flash_addr;
    logic flash_scratch, xram_wr;
    logic [7:0] flash_wdata, flash_rdata, xram_wdata;
    logic [15:0] xram_addr;
    logic [7:0] store_v = 8'h00;
    int mismatches = 0, total_checks = 0, cycles = 0;

    fsag_guard dut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .core_req, .core_ready, .core_op,
        .core_addr, .core_pc, .core_wdata, .core_ack, .core_denied,
        .core_rdata, .dbg_req, .dbg_op, .dbg_scratch, .dbg_addr,
        .dbg_wdata, .dbg_ack, .dbg_denied, .dbg_rdata, .lock_rd_byte,
        .lock_we_byte, .flash_cmd, .flash_addr, .flash_scratch,
        .flash_wdata, .flash_rdata, .flash_read_time, .xram_wr,
        .xram_addr, .xram_wdata);
    fsag_flash_model array_model (.sys_clk, .flash_cmd, .flash_addr,
        .flash_rdata);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a run far past the expected 150 or so cycles means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [16:0] got, input logic [16:0] exp,
            input string m);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, m, got,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= v;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        // let the written register settle before any caller looks at it
        #1;
        if (a == 8'hB9) begin
            store_v = v;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, e, "register read");
    endtask

    task automatic locks(input logic [7:0] r, input logic [7:0] w);
        @(posedge sys_clk);
        lock_rd_byte <= r;
        lock_we_byte <= w;
    endtask

    // one request on the core (d=0) or debug (d=1) port, judged fully
    task automatic xfer(input bit d, input logic [1:0] op,
            input logic [16:0] a, input logic [16:0] pc, input bit scr,
            input fsag_pkg::fsag_cmd_t cmd, input bit den, input bit xw);
        @(posedge sys_clk);
        if (d) begin
            dbg_req <= 1'b1;
            dbg_op <= op;
            dbg_addr <= a;
            dbg_scratch <= scr;
            #1;
            chk(core_ready, 1'b0, "debug priority");
        end else begin
            core_req <= 1'b1;
            core_op <= op;
            core_addr <= a;
            core_pc <= pc;
        end
        @(posedge sys_clk);
        dbg_req <= 1'b0;
        core_req <= 1'b0;
        #1;
        chk(flash_cmd, cmd, "flash command");
        chk(xram_wr, xw, "xram strobe");
        if (cmd != fsag_pkg::CMD_NONE) begin
            chk(flash_addr, a, "flash address");
            chk(flash_scratch, d ? scr : store_v[2], "scratch steer");
        end
        if (cmd == fsag_pkg::CMD_PROG) begin
            chk(flash_wdata, 8'hC3, "flash data");
        end
        if (xw) begin
            chk(xram_addr, a[15:0], "xram address");
            chk(xram_wdata, 8'hC3, "xram data");
        end
        @(posedge sys_clk);
        #1;
        chk(d ? dbg_ack : core_ack, 1'b1, "ack");
        chk(d ? dbg_denied : core_denied, den, "denied flag");
        if (den || cmd == fsag_pkg::CMD_READ) begin
            chk(d ? dbg_rdata : core_rdata, den ? 8'h00 : a[7:0] ^ 8'h3C,
                "read data");
        end
    endtask

    task automatic t_regs();
        rd(8'hB7, 8'h80);
        rd(8'hB9, 8'h00);
        wr(8'hB7, 8'hFF);
        rd(8'hB7, 8'hF1);
        chk(flash_read_time, 2'h3, "read time");
        wr(8'hB7, 8'hA1);
        chk(flash_read_time, 2'h2, "read time");
        wr(8'hB9, 8'hFF);
        rd(8'hB9, 8'h07);
        wr(8'hB9, 8'h00);
        wr(8'hBA, 8'h55);
        rd(8'hBA, 8'h00);
    endtask

    task automatic t_limit();
        rd(8'hB8, 8'h00);
        wr(8'hB8, 8'h40);
        rd(8'hB8, 8'h40);
        wr(8'hB8, 8'h10);
        rd(8'hB8, 8'h40);
    endtask

    // software writes, erases and steering, run from the lower partition
    task automatic t_core();
        wr(8'hB7, 8'hA0);
        wr(8'hB9, 8'h01);
        xfer(0, 2'h2, 17'h12345, 17'h00100, 0, fsag_pkg::CMD_NONE, 1, 0);
        wr(8'hB7, 8'hA1);
        xfer(0, 2'h2, 17'h12345, 17'h00100, 0, fsag_pkg::CMD_PROG, 0, 0);
        wr(8'hB9, 8'h00);
        xfer(0, 2'h2, 17'h12345, 17'h00100, 0, fsag_pkg::CMD_NONE, 0, 1);
        wr(8'hB9, 8'h03);
        xfer(0, 2'h2, 17'h12345, 17'h00100, 0, fsag_pkg::CMD_ERASE_PAGE,
            0, 0);
        xfer(0, 2'h2, 17'h1F900, 17'h00100, 0, fsag_pkg::CMD_NONE, 1, 0);
        wr(8'hB9, 8'h01);
        xfer(0, 2'h2, 17'h1FBFE, 17'h00100, 0, fsag_pkg::CMD_PROG, 0, 0);
    endtask

    // limit sits at 0x08000 after the single accepted limit write
    task automatic t_partition();
        xfer(0, 2'h1, 17'h07FFF, 17'h08000, 0, fsag_pkg::CMD_NONE, 1, 0);
        xfer(0, 2'h1, 17'h08000, 17'h08000, 0, fsag_pkg::CMD_READ, 0, 0);
        xfer(0, 2'h2, 17'h00200, 17'h09000, 0, fsag_pkg::CMD_NONE, 1, 0);
        xfer(0, 2'h0, 17'h01000, 17'h09000, 0, fsag_pkg::CMD_READ, 0, 0);
        xfer(0, 2'h1, 17'h01000, 17'h07FFF, 0, fsag_pkg::CMD_READ, 0, 0);
    endtask

    task automatic t_scratch();
        wr(8'hB9, 8'h05);
        xfer(0, 2'h1, 17'h00080, 17'h00100, 0, fsag_pkg::CMD_READ, 0, 0);
        xfer(0, 2'h2, 17'h000FF, 17'h00100, 0, fsag_pkg::CMD_PROG, 0, 0);
        xfer(0, 2'h2, 17'h00200, 17'h00100, 0, fsag_pkg::CMD_NONE, 1, 0);
        wr(8'hB9, 8'h07);
        xfer(0, 2'h2, 17'h00400, 17'h00100, 0, fsag_pkg::CMD_ERASE_SCR,
            0, 0);
        wr(8'hB9, 8'h00);
    endtask

    task automatic t_debug();
        locks(8'h7E, 8'h7F);
        xfer(1, 2'h0, 17'h00100, 17'h0, 0, fsag_pkg::CMD_NONE, 1, 0);
        xfer(1, 2'h0, 17'h04000, 17'h0, 0, fsag_pkg::CMD_READ, 0, 0);
        xfer(1, 2'h0, 17'h1C000, 17'h0, 0, fsag_pkg::CMD_NONE, 1, 0);
        xfer(1, 2'h1, 17'h00100, 17'h0, 0, fsag_pkg::CMD_PROG, 0, 0);
        xfer(1, 2'h0, 17'h1FBFF, 17'h0, 0, fsag_pkg::CMD_READ, 0, 0);
        xfer(1, 2'h1, 17'h1C000, 17'h0, 0, fsag_pkg::CMD_NONE, 1, 0);
        xfer(1, 2'h1, 17'h1FBFE, 17'h0, 0, fsag_pkg::CMD_PROG, 0, 0);
        xfer(1, 2'h2, 17'h1FBFF, 17'h0, 0, fsag_pkg::CMD_ERASE_ALL, 0, 0);
        xfer(1, 2'h2, 17'h1F900, 17'h0, 0, fsag_pkg::CMD_NONE, 1, 0);
        locks(8'h00, 8'hFF);
        xfer(1, 2'h2, 17'h1F900, 17'h0, 0, fsag_pkg::CMD_ERASE_PAGE,
            0, 0);
        xfer(1, 2'h0, 17'h00010, 17'h0, 1, fsag_pkg::CMD_NONE, 1, 0);
        locks(8'h01, 8'hFF);
        xfer(1, 2'h0, 17'h00010, 17'h0, 1, fsag_pkg::CMD_READ, 0, 0);
    endtask

    // a second reset must rearm the single limit write
    task automatic t_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'hB8, 8'h00);
        rd(8'hB7, 8'h80);
        wr(8'hB8, 8'h20);
        rd(8'hB8, 8'h20);
        wr(8'hB8, 8'h08);
        rd(8'hB8, 8'h20);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_limit();
        t_core();
        t_partition();
        t_scratch();
        t_debug();
        t_reset();
        finish_test();
    end
endmodule // test_flash_security_access_guard

// [hw/fsag_guard.sv]
// flash security access guard: sfr registers, core and debug gating
`timescale 1ns/1ps
module fsag_guard (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic core_req,
    output logic core_ready,
    input wire logic [1:0] core_op,
    input wire logic [16:0] core_addr,
    input wire logic [16:0] core_pc,
    input wire logic [7:0] core_wdata,
    output logic core_ack,
    output logic core_denied,
    output logic [7:0] core_rdata,
    input wire logic dbg_req,
    input wire logic [1:0] dbg_op,
    input wire logic dbg_scratch,
    input wire logic [16:0] dbg_addr,
    input wire logic [7:0] dbg_wdata,
    output logic dbg_ack,
    output logic dbg_denied,
    output logic [7:0] dbg_rdata,
    input wire logic [7:0] lock_rd_byte,
    input wire logic [7:0] lock_we_byte,
    output fsag_pkg::fsag_cmd_t flash_cmd,
    output logic [16:0] flash_addr,
    output logic flash_scratch,
    output logic [7:0] flash_wdata,
    input wire logic [7:0] flash_rdata,
    output logic [1:0] flash_read_time,
    output logic xram_wr,
    output logic [15:0] xram_addr,
    output logic [7:0] xram_wdata
);
    typedef struct packed {
        logic [7:0] timing;
        logic [7:0] store;
        logic [7:0] limit;
        logic limit_done;
        logic [7:0] sfr_rdata;
        fsag_pkg::fsag_cmd_t cmd;
        logic [16:0] faddr;
        logic fscr;
        logic [7:0] fwdata;
        logic core_pend;
        logic core_deny;
        logic dbg_pend;
        logic dbg_deny;
        logic core_ack;
        logic core_denied;
        logic [7:0] core_rdata;
        logic dbg_ack;
        logic dbg_denied;
        logic [7:0] dbg_rdata;
        logic xram_wr;
        logic [15:0] xram_addr;
        logic [7:0] xram_wdata;
    } fsag_state_t;

    fsag_state_t q_ff;
    fsag_state_t nxt_q;

    function automatic logic [7:0] reg_read(
        input logic [7:0] addr,
        input logic [7:0] timing,
        input logic [7:0] store,
        input logic [7:0] limit
    );
        case (addr)
            fsag_pkg::TIMING_OFS: reg_read = timing;
            fsag_pkg::STORE_OFS: reg_read = store;
            fsag_pkg::LIMIT_OFS: reg_read = limit;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // true when the lock byte forbids the debug access
    function automatic logic locked(
        input logic [7:0] lock_byte,
        input logic [16:0] addr,
        input logic scratch
    );
        if (scratch) begin
            locked = (lock_byte == 8'h00);
        end else begin
            locked = !lock_byte[addr[16:fsag_pkg::REGION_LSB]];
        end
    endfunction

    logic flash_write_erase_enable;
    logic program_write_enable;
    logic program_erase_enable;
    logic scratchpad_select;
    logic [16:0] limit_addr;
    logic core_upper;
    logic core_below;
    logic dbg_is_lock;
    logic dbg_lock_page;
    logic core_lock_page;

    assign flash_write_erase_enable = q_ff.timing[fsag_pkg::FLASH_WRITE_ERASE_ENABLE_BIT];
    assign program_write_enable = q_ff.store[fsag_pkg::PROGRAM_WRITE_ENABLE_BIT];
    assign program_erase_enable = q_ff.store[fsag_pkg::PROGRAM_ERASE_ENABLE_BIT];
    assign scratchpad_select = q_ff.store[fsag_pkg::SCRATCHPAD_SELECT_BIT];
    assign limit_addr = {q_ff.limit, {fsag_pkg::LIMIT_LSB{1'b0}}};
    assign core_upper = (core_pc >= limit_addr);
    assign core_below = (core_addr < limit_addr);
    assign dbg_is_lock = !dbg_scratch &&
        (dbg_addr == fsag_pkg::LOCK_RD_ADDR ||
         dbg_addr == fsag_pkg::LOCK_WE_ADDR);
    assign dbg_lock_page = !dbg_scratch &&
        (dbg_addr[16:fsag_pkg::PAGE_LSB] == fsag_pkg::LOCK_PAGE);
    assign core_lock_page =
        (core_addr[16:fsag_pkg::PAGE_LSB] == fsag_pkg::LOCK_PAGE);

    // debug port always wins the single flash port
    assign core_ready = !dbg_req;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.cmd = fsag_pkg::CMD_NONE;
        nxt_q.core_pend = 1'b0;
        nxt_q.dbg_pend = 1'b0;
        nxt_q.core_ack = 1'b0;
        nxt_q.dbg_ack = 1'b0;
        nxt_q.xram_wr = 1'b0;
        nxt_q.core_deny = 1'b0;
        nxt_q.dbg_deny = 1'b0;
        nxt_q.fscr = 1'b0;

        // answer stage: flash data is valid while the command stands
        if (q_ff.core_pend) begin
            nxt_q.core_ack = 1'b1;
            nxt_q.core_denied = q_ff.core_deny;
            nxt_q.core_rdata = q_ff.core_deny ? fsag_pkg::FILL_BYTE
                                              : flash_rdata;
        end
        if (q_ff.dbg_pend) begin
            nxt_q.dbg_ack = 1'b1;
            nxt_q.dbg_denied = q_ff.dbg_deny;
            nxt_q.dbg_rdata = q_ff.dbg_deny ? fsag_pkg::FILL_BYTE
                                            : flash_rdata;
        end

        if (sfr_rd) begin
            nxt_q.sfr_rdata = reg_read(sfr_addr, q_ff.timing, q_ff.store,
                                       q_ff.limit);
        end
        if (sfr_wr) begin
            case (sfr_addr)
                fsag_pkg::TIMING_OFS: begin
                    // read time is stored only; software picks it
                    nxt_q.timing = sfr_wdata & fsag_pkg::TIMING_WMASK;
                end
                fsag_pkg::STORE_OFS: begin
                    nxt_q.store = sfr_wdata & fsag_pkg::STORE_WMASK;
                end
                fsag_pkg::LIMIT_OFS: begin
                    if (!q_ff.limit_done) begin
                        nxt_q.limit = sfr_wdata;
                        nxt_q.limit_done = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        if (dbg_req) begin
            nxt_q.dbg_pend = 1'b1;
            nxt_q.faddr = dbg_addr;
            nxt_q.fscr = dbg_scratch;
            nxt_q.fwdata = dbg_wdata;
            case (dbg_op)
                fsag_pkg::DBG_READ: begin
                    nxt_q.cmd = fsag_pkg::CMD_READ;
                    nxt_q.dbg_deny = !dbg_is_lock &&
                        locked(lock_rd_byte, dbg_addr, dbg_scratch);
                end
                fsag_pkg::DBG_PROG: begin
                    // array ANDs data in, so a program only clears bits
                    nxt_q.cmd = fsag_pkg::CMD_PROG;
                    nxt_q.dbg_deny = !dbg_is_lock &&
                        locked(lock_we_byte, dbg_addr, dbg_scratch);
                end
                fsag_pkg::DBG_ERASE: begin
                    if (dbg_is_lock) begin
                        // only way to lift a lock once region 7 is write-locked; reserved area kept
                        nxt_q.cmd = fsag_pkg::CMD_ERASE_ALL;
                    end else begin
                        // lock page erase takes lock bytes with it
                        nxt_q.cmd = fsag_pkg::CMD_ERASE_PAGE;
                        nxt_q.dbg_deny =
                            locked(lock_we_byte, dbg_addr, dbg_scratch);
                    end
                end
                default: begin
                    nxt_q.dbg_deny = 1'b1;
                end
            endcase
            if (nxt_q.dbg_deny) begin
                nxt_q.cmd = fsag_pkg::CMD_NONE;
            end
        end else if (core_req) begin
            nxt_q.core_pend = 1'b1;
            nxt_q.faddr = core_addr;
            nxt_q.fwdata = core_wdata;
            case (core_op)
                fsag_pkg::OP_FETCH: begin
                    nxt_q.cmd = fsag_pkg::CMD_READ;
                end
                fsag_pkg::OP_CODE_CONSTANT_READ: begin
                    nxt_q.cmd = fsag_pkg::CMD_READ;
                    if (scratchpad_select) begin
                        nxt_q.fscr = 1'b1;
                        nxt_q.core_deny =
                            (core_addr > fsag_pkg::SCRATCH_TOP);
                    end else begin
                        nxt_q.core_deny = core_upper && core_below;
                    end
                end
                fsag_pkg::OP_DATA_MOVE_INSTRUCTION: begin
                    if (!program_write_enable) begin
                        nxt_q.cmd = fsag_pkg::CMD_NONE;
                        nxt_q.xram_wr = 1'b1;
                        nxt_q.xram_addr = core_addr[15:0];
                        nxt_q.xram_wdata = core_wdata;
                    end else begin
                        nxt_q.cmd = program_erase_enable ? fsag_pkg::CMD_ERASE_PAGE
                                         : fsag_pkg::CMD_PROG;
                        nxt_q.core_deny = !flash_write_erase_enable;
                        if (scratchpad_select) begin
                            nxt_q.fscr = 1'b1;
                            if (program_erase_enable && core_addr ==
                                fsag_pkg::SCRATCH_ERASE_ADDR) begin
                                nxt_q.cmd = fsag_pkg::CMD_ERASE_SCR;
                            end else if (core_addr >
                                         fsag_pkg::SCRATCH_TOP) begin
                                nxt_q.core_deny = 1'b1;
                            end
                        end else begin
                            if (core_upper && core_below) begin
                                nxt_q.core_deny = 1'b1;
                            end
                            if (program_erase_enable && core_lock_page) begin
                                nxt_q.core_deny = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    nxt_q.core_deny = 1'b1;
                end
            endcase
            if (nxt_q.core_deny) begin
                nxt_q.cmd = fsag_pkg::CMD_NONE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_ff <= '0;
            q_ff.timing <= fsag_pkg::TIMING_RST;
            q_ff.store <= fsag_pkg::STORE_RST;
            q_ff.limit <= fsag_pkg::LIMIT_RST;
            q_ff.cmd <= fsag_pkg::CMD_NONE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign sfr_rdata = q_ff.sfr_rdata;
    assign core_ack = q_ff.core_ack;
    assign core_denied = q_ff.core_denied;
    assign core_rdata = q_ff.core_rdata;
    assign dbg_ack = q_ff.dbg_ack;
    assign dbg_denied = q_ff.dbg_denied;
    assign dbg_rdata = q_ff.dbg_rdata;
    assign flash_cmd = q_ff.cmd;
    assign flash_addr = q_ff.faddr;
    assign flash_scratch = q_ff.fscr;
    assign flash_wdata = q_ff.fwdata;
    assign flash_read_time = q_ff.timing[fsag_pkg::FLASH_READ_TIME_LSB +: 2];
    assign xram_wr = q_ff.xram_wr;
    assign xram_addr = q_ff.xram_addr;
    assign xram_wdata = q_ff.xram_wdata;

    chk_flash_write_erase_enable_gate: assert property (
        @(posedge sys_clk) disable iff (rst)
        core_req && core_ready && core_op == fsag_pkg::OP_DATA_MOVE_INSTRUCTION && program_write_enable &&
        !flash_write_erase_enable |=> flash_cmd == fsag_pkg::CMD_NONE ##1 core_ack && core_denied)
        else $error("flash write passed with enable clear");

    chk_read_lock: assert property (
        @(posedge sys_clk) disable iff (rst)
        dbg_req && dbg_op == fsag_pkg::DBG_READ && !dbg_scratch &&
        !dbg_is_lock && !lock_rd_byte[dbg_addr[16:14]]
        |-> ##2 dbg_ack && dbg_denied && dbg_rdata == fsag_pkg::FILL_BYTE)
        else $error("read-locked debug read not refused");

    chk_write_lock: assert property (
        @(posedge sys_clk) disable iff (rst)
        dbg_req && dbg_op == fsag_pkg::DBG_PROG && !dbg_scratch &&
        !dbg_is_lock && !lock_we_byte[dbg_addr[16:14]]
        |=> flash_cmd == fsag_pkg::CMD_NONE)
        else $error("write-locked debug program issued");

    chk_lock_page_keep: assert property (
        @(posedge sys_clk) disable iff (rst)
        core_req && core_ready && core_op == fsag_pkg::OP_DATA_MOVE_INSTRUCTION && program_write_enable &&
        program_erase_enable && !scratchpad_select && core_lock_page
        |=> flash_cmd != fsag_pkg::CMD_ERASE_PAGE ##1 core_denied)
        else $error("software erased the lock page");

    chk_mass_erase: assert property (
        @(posedge sys_clk) disable iff (rst)
        dbg_req && dbg_op == fsag_pkg::DBG_ERASE && dbg_is_lock
        |=> flash_cmd == fsag_pkg::CMD_ERASE_ALL ##1 dbg_ack && !dbg_denied)
        else $error("lock byte erase did not erase all");

    chk_limit_once: assert property (
        @(posedge sys_clk) disable iff (rst)
        q_ff.limit_done |=> q_ff.limit_done && $stable(q_ff.limit))
        else $error("access limit changed after first write");

    chk_upper_block: assert property (
        @(posedge sys_clk) disable iff (rst)
        core_req && core_ready && core_op == fsag_pkg::OP_CODE_CONSTANT_READ && !scratchpad_select &&
        core_upper && core_below
        |-> ##2 core_ack && core_denied &&
        core_rdata == fsag_pkg::FILL_BYTE)
        else $error("upper code read below the limit");

    chk_xram_route: assert property (
        @(posedge sys_clk) disable iff (rst)
        core_req && core_ready && core_op == fsag_pkg::OP_DATA_MOVE_INSTRUCTION && !program_write_enable
        |=> xram_wr && flash_cmd == fsag_pkg::CMD_NONE &&
        xram_addr == $past(core_addr[15:0]))
        else $error("data move not routed to data ram");

    chk_fetch_free: assert property (
        @(posedge sys_clk) disable iff (rst)
        core_req && core_ready && core_op == fsag_pkg::OP_FETCH
        |=> flash_cmd == fsag_pkg::CMD_READ ##1 core_ack && !core_denied)
        else $error("instruction fetch was refused");
endmodule // fsag_guard

// [hw/fsag_pkg.sv]
// constants and types shared by the flash security access guard
// Behaviour
// - software write/erase needs write-erase enable bit
// - read lock top byte, write lock below
// - lock bit n guards 16k region n
// - read-locked region refuses debug reads, undefined data
// - write-locked region refuses debug writes and erases
// - scratchpad locked only when all regions locked
// - software may program, never erase, lock page
// - lock bytes always readable and clearable
// - debug erase of lock byte erases all
// - debug erase elsewhere in lock page erases page
// - limit address is register with nine zeros
// - upper code cannot touch flash below limit
// - lower code free; fetches always allowed
// - access limit accepts only first write
// - unwritten limit is zero, all readable
// - scratchpad select steers accesses to scratch sectors
// - erase plus write enable erases whole page
// - write enable routes data moves to flash
// - erase sets ones, program only clears bits
package fsag_pkg;
    localparam int ADDR_W = 17;
    localparam logic [7:0] TIMING_OFS = 8'hB7;
    localparam logic [7:0] LIMIT_OFS = 8'hB8;
    localparam logic [7:0] STORE_OFS = 8'hB9;
    localparam logic [7:0] TIMING_RST = 8'h80;
    localparam logic [7:0] STORE_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'h00;
    localparam logic [7:0] TIMING_WMASK = 8'hF1;
    localparam logic [7:0] STORE_WMASK = 8'h07;
    localparam int FLASH_WRITE_ERASE_ENABLE_BIT = 0;
    localparam int FLASH_READ_TIME_LSB = 4;
    localparam int PROGRAM_WRITE_ENABLE_BIT = 0;
    localparam int PROGRAM_ERASE_ENABLE_BIT = 1;
    localparam int SCRATCHPAD_SELECT_BIT = 2;
    localparam logic [16:0] LOCK_RD_ADDR = 17'h1FBFF;
    localparam logic [16:0] LOCK_WE_ADDR = 17'h1FBFE;
    localparam int REGION_LSB = 14;
    localparam int PAGE_LSB = 10;
    localparam int LIMIT_LSB = 9;
    localparam logic [6:0] LOCK_PAGE = 7'h7E;
    localparam logic [2:0] LOCK_REGION = 3'h7;
    localparam logic [16:0] SCRATCH_TOP = 17'h000FF;
    localparam logic [16:0] SCRATCH_ERASE_ADDR = 17'h00400;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic [1:0] OP_FETCH = 2'h0;
    localparam logic [1:0] OP_CODE_CONSTANT_READ = 2'h1;
    localparam logic [1:0] OP_DATA_MOVE_INSTRUCTION = 2'h2;
    localparam logic [1:0] DBG_READ = 2'h0;
    localparam logic [1:0] DBG_PROG = 2'h1;
    localparam logic [1:0] DBG_ERASE = 2'h2;
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ,
        CMD_PROG,
        CMD_ERASE_PAGE,
        CMD_ERASE_ALL,
        CMD_ERASE_SCR
    } fsag_cmd_t;
endpackage
